// >>> hdl/comparator_control_logic.sv
// Digital control around an analog voltage comparator: input selection,
// result synchroniser, event detection, interrupt flag and capture routing.
// Assumes the analog comparator and pins are asynchronous to i_mclk and that
// converter enable, channel select, global enable and vector ack are on i_mclk.
//
// Behaviour
// - Result bit reads one when positive input exceeds negative input.
// - Mux enable set and converter off selects channel 0-7 as negative input.
// - Bandgap select feeds internal reference to positive input, else pin.
// - Raw comparator output is synchronised, one to two cycles latency.
// - Interrupt flag sets on the event chosen by the mode field.
// - Mode 00 toggle, 01 reserved, 10 falling, 11 rising.
// - Interrupt requested only with flag, enable and global enable all one.
// - Flag clears when the processor takes the comparator vector.
// - Writing one to the flag clears it; zero leaves it.
// - Writing one to the power-off bit switches comparator power off.
// - Capture route bit feeds comparator output to the timer capture input.
// - Buffer-off bit disables pin input buffer; pin level reads zero.
// - Converter control B holds mux enable bit 6, trigger bits 2-0.
`timescale 1ns/1ns
module comparator_control_logic (
    // Clock and reset
    input  wire logic                           i_mclk,
    input  wire logic                           i_resetn,
    // Register port
    input  wire comparator_control_pkg::reg_req_t i_req,
    output logic [7:0]                          o_rdata,
    // Analog side
    input  wire logic                           i_cmp_raw,
    output logic                                o_bandgap_select,
    output comparator_control_pkg::neg_sel_t    o_neg_sel,
    output logic                                o_comparator_power_off,
    // Converter context
    input  wire logic                           i_converter_enable,
    input  wire logic [2:0]                     i_channel_select,
    output logic [2:0]                          o_trigger_source_select,
    // Interrupt context
    input  wire logic                           i_global_irq_enable,
    input  wire logic                           i_vector_taken,
    output logic                                o_irq,
    // Timer capture front end
    input  wire logic                           i_capture_pin,
    output logic                                o_capture_source,
    // Comparator pins, digital side
    input  wire logic                           i_positive_input_pin,
    input  wire logic                           i_negative_input_pin,
    output logic                                o_positive_pin_buffer_off,
    output logic                                o_negative_pin_buffer_off,
    output logic [1:0]                          o_pin_level
);
    import comparator_control_pkg::*;

    logic [7:0] conv_b_r;
    logic [7:0] control_r;
    logic [1:0] buf_off_r;
    logic [7:0] rdata_r;
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic       prev_r;
    logic       result;
    logic       event_hit;
    logic       flag_clear;
    logic       flag_nxt;
    logic       wr_conv_b;
    logic       wr_control;
    logic       wr_buf_off;

    assign wr_conv_b  = i_req.we && (i_req.addr == CONVERTER_CONTROL_B_ADDR);
    assign wr_control = i_req.we && (i_req.addr == COMPARATOR_CONTROL_STATUS_ADDR);
    assign wr_buf_off = i_req.we && (i_req.addr == DIGITAL_INPUT_DISABLE_ONE_ADDR);

    // Two-flop synchronisers: comparator, capture pin, both comparator pins
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
        end else begin
            sync1_r <= {i_negative_input_pin, i_positive_input_pin, i_capture_pin, i_cmp_raw};
            sync2_r <= sync1_r;
        end
    end

    assign result = sync2_r[0];

    // Previous synchronised value for edge detection
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= result;
        end
    end

    // Event selection; the reserved code never raises the flag
    always_comb begin
        unique case (control_r[MODE_MSB:0])
            MODE_TOGGLE:   event_hit = result ^ prev_r;
            MODE_FALLING:  event_hit = prev_r & ~result;
            MODE_RISING:   event_hit = ~prev_r & result;
            MODE_RESERVED: event_hit = 1'b0;
        endcase
    end

    // An event in the clearing cycle wins, so it is never lost
    assign flag_clear = i_vector_taken
                        || (wr_control && i_req.wdata[IRQ_FLAG_BIT]);
    assign flag_nxt   = event_hit || (control_r[IRQ_FLAG_BIT] && !flag_clear);

    // Comparator control and status register
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            control_r <= CONTROL_RESET;
        end else begin
            control_r[IRQ_FLAG_BIT] <= flag_nxt;
            control_r[RESULT_BIT]   <= 1'b0;
            if (wr_control) begin
                control_r[POWER_OFF_BIT]     <= i_req.wdata[POWER_OFF_BIT];
                control_r[BANDGAP_BIT]       <= i_req.wdata[BANDGAP_BIT];
                control_r[IRQ_ENABLE_BIT]    <= i_req.wdata[IRQ_ENABLE_BIT];
                control_r[CAPTURE_ROUTE_BIT] <= i_req.wdata[CAPTURE_ROUTE_BIT];
                control_r[MODE_MSB:0]        <= i_req.wdata[MODE_MSB:0];
            end
        end
    end

    // Converter control B: only mux enable and trigger select are stored
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            conv_b_r <= CONV_B_RESET;
        end else if (wr_conv_b) begin
            conv_b_r <= i_req.wdata & CONV_B_READ_MASK;
        end
    end

    // Digital input buffer disables
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            buf_off_r <= BUF_OFF_RESET;
        end else if (wr_buf_off) begin
            buf_off_r <= i_req.wdata[1:0];
        end
    end

    // Read data stands for the cycle after the strobe only
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_r <= 8'h00;
        end else if (i_req.re) begin
            unique case (i_req.addr)
                CONVERTER_CONTROL_B_ADDR:       rdata_r <= conv_b_r;
                COMPARATOR_CONTROL_STATUS_ADDR: begin
                    rdata_r             <= control_r;
                    rdata_r[RESULT_BIT] <= result;
                end
                DIGITAL_INPUT_DISABLE_ONE_ADDR: rdata_r <= {6'h00, buf_off_r};
                default:                        rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign o_rdata = rdata_r;

    // Analog selection
    assign o_bandgap_select       = control_r[BANDGAP_BIT];
    assign o_neg_sel = '{use_channel: conv_b_r[MUX_ENABLE_BIT] && !i_converter_enable,
                         channel:     i_channel_select};
    assign o_comparator_power_off = control_r[POWER_OFF_BIT];
    assign o_trigger_source_select = conv_b_r[TRIGGER_MSB:0];

    // Interrupt request is a level while all three terms hold
    assign o_irq = control_r[IRQ_FLAG_BIT] && control_r[IRQ_ENABLE_BIT]
                   && i_global_irq_enable;

    // Capture input uses the synchronised result when routed, else the synchronised pin; both have the 1-2 cycle lag
    assign o_capture_source = control_r[CAPTURE_ROUTE_BIT] ? result : sync2_r[1];

    // Pin buffers and pin-level reads
    assign o_positive_pin_buffer_off = buf_off_r[POS_BUF_OFF_BIT];
    assign o_negative_pin_buffer_off = buf_off_r[NEG_BUF_OFF_BIT];
    assign o_pin_level = {sync2_r[3] && !buf_off_r[NEG_BUF_OFF_BIT],
                          sync2_r[2] && !buf_off_r[POS_BUF_OFF_BIT]};

    // Checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    // Synchronisers restart from zero, so the first two edges after reset are skipped
    property p_result_latency;
        $past(i_resetn, 2) |-> result == $past(i_cmp_raw, 2);
    endproperty
    a_result_latency: assert property (p_result_latency)
        else $error("result does not follow raw input after two edges");

    property p_result_read;
        i_req.re && i_req.addr == COMPARATOR_CONTROL_STATUS_ADDR
            |=> o_rdata[RESULT_BIT] == $past(result);
    endproperty
    a_result_read: assert property (p_result_read)
        else $error("result bit read wrong");

    property p_neg_select;
        wr_conv_b |=> o_neg_sel.use_channel == ($past(i_req.wdata[MUX_ENABLE_BIT])
                                                && !i_converter_enable);
    endproperty
    a_neg_select: assert property (p_neg_select)
        else $error("negative input selection wrong");

    property p_bandgap;
        wr_control |=> o_bandgap_select == $past(i_req.wdata[BANDGAP_BIT]);
    endproperty
    a_bandgap: assert property (p_bandgap)
        else $error("bandgap select not taken from write");

    property p_rising_sets;
        control_r[MODE_MSB:0] == MODE_RISING && !prev_r && result
            |=> control_r[IRQ_FLAG_BIT];
    endproperty
    a_rising_sets: assert property (p_rising_sets)
        else $error("rising edge missed");

    property p_falling_sets;
        control_r[MODE_MSB:0] == MODE_FALLING && prev_r && !result
            |=> control_r[IRQ_FLAG_BIT];
    endproperty
    a_falling_sets: assert property (p_falling_sets)
        else $error("falling edge missed");

    property p_reserved_quiet;
        $rose(control_r[IRQ_FLAG_BIT]) |-> $past(control_r[MODE_MSB:0]) != MODE_RESERVED;
    endproperty
    a_reserved_quiet: assert property (p_reserved_quiet)
        else $error("flag set in reserved mode");

    property p_irq_gate;
        o_irq |-> control_r[IRQ_FLAG_BIT] && control_r[IRQ_ENABLE_BIT] && i_global_irq_enable;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt without all enables");

    property p_vector_clears;
        i_vector_taken && !event_hit |=> !control_r[IRQ_FLAG_BIT];
    endproperty
    a_vector_clears: assert property (p_vector_clears)
        else $error("vector did not clear flag");

    property p_write_clear;
        wr_control && !event_hit && !i_vector_taken
            |=> control_r[IRQ_FLAG_BIT] == ($past(control_r[IRQ_FLAG_BIT])
                && !$past(i_req.wdata[IRQ_FLAG_BIT]));
    endproperty
    a_write_clear: assert property (p_write_clear)
        else $error("flag write-one-to-clear wrong");

    property p_power_off;
        wr_control |=> o_comparator_power_off == $past(i_req.wdata[POWER_OFF_BIT]);
    endproperty
    a_power_off: assert property (p_power_off)
        else $error("power off not taken from write");

    property p_capture_route;
        control_r[CAPTURE_ROUTE_BIT] |-> o_capture_source == result;
    endproperty
    a_capture_route: assert property (p_capture_route)
        else $error("capture source not comparator");

    property p_pin_zero;
        buf_off_r[POS_BUF_OFF_BIT] |-> !o_pin_level[0];
    endproperty
    a_pin_zero: assert property (p_pin_zero)
        else $error("disabled pin reads one");

    property p_conv_b_read;
        i_req.re && i_req.addr == CONVERTER_CONTROL_B_ADDR
            |=> (o_rdata & ~CONV_B_READ_MASK) == 8'h00;
    endproperty
    a_conv_b_read: assert property (p_conv_b_read)
        else $error("read-only bits of converter control b not zero");

    property p_edge_only;
        $rose(control_r[IRQ_FLAG_BIT]) |-> $past(result) != $past(prev_r);
    endproperty
    a_edge_only: assert property (p_edge_only)
        else $error("flag set without an edge");

    property p_toggle_sets;
        control_r[MODE_MSB:0] == MODE_TOGGLE && result != prev_r |=> control_r[IRQ_FLAG_BIT];
    endproperty
    a_toggle_sets: assert property (p_toggle_sets)
        else $error("toggle missed");

    property p_flag_holds;
        control_r[IRQ_FLAG_BIT] && !i_vector_taken
            && !(wr_control && i_req.wdata[IRQ_FLAG_BIT]) |=> control_r[IRQ_FLAG_BIT];
    endproperty
    a_flag_holds: assert property (p_flag_holds)
        else $error("flag lost without a clear");

    property p_flag_quiet;
        !control_r[IRQ_FLAG_BIT] && !event_hit |=> !control_r[IRQ_FLAG_BIT];
    endproperty
    a_flag_quiet: assert property (p_flag_quiet)
        else $error("flag set without an event");

    property p_irq_raise;
        control_r[IRQ_FLAG_BIT] && control_r[IRQ_ENABLE_BIT] && i_global_irq_enable |-> o_irq;
    endproperty
    a_irq_raise: assert property (p_irq_raise)
        else $error("interrupt not requested");

    property p_vector_irq;
        i_vector_taken && !event_hit |=> !o_irq;
    endproperty
    a_vector_irq: assert property (p_vector_irq)
        else $error("request stays after vector");

    property p_power_hold;
        !wr_control |=> $stable(o_comparator_power_off);
    endproperty
    a_power_hold: assert property (p_power_hold)
        else $error("power off changed without a write");

    property p_capture_pin;
        $past(i_resetn, 2) && !control_r[CAPTURE_ROUTE_BIT]
            |-> o_capture_source == $past(i_capture_pin, 2);
    endproperty
    a_capture_pin: assert property (p_capture_pin)
        else $error("capture source not the pin");

    property p_neg_pin_zero;
        buf_off_r[NEG_BUF_OFF_BIT] |-> !o_pin_level[1];
    endproperty
    a_neg_pin_zero: assert property (p_neg_pin_zero)
        else $error("disabled negative pin reads one");

    property p_buf_write;
        wr_buf_off |=> o_positive_pin_buffer_off == $past(i_req.wdata[POS_BUF_OFF_BIT])
                       && o_negative_pin_buffer_off == $past(i_req.wdata[NEG_BUF_OFF_BIT]);
    endproperty
    a_buf_write: assert property (p_buf_write)
        else $error("buffer disables not taken from write");

    property p_trigger_write;
        wr_conv_b |=> o_trigger_source_select == $past(i_req.wdata[TRIGGER_MSB:0]);
    endproperty
    a_trigger_write: assert property (p_trigger_write)
        else $error("trigger select not taken from write");

endmodule

// >>> include/comparator_control_pkg.sv
// Constants and carrier types for the comparator control logic.
// Assumes an 8-bit register port on the single system clock.
package comparator_control_pkg;

    // Register offsets
    localparam logic [7:0] CONVERTER_CONTROL_B_ADDR       = 8'h7B;
    localparam logic [7:0] COMPARATOR_CONTROL_STATUS_ADDR = 8'h50;
    localparam logic [7:0] DIGITAL_INPUT_DISABLE_ONE_ADDR = 8'h7F;

    // converter_control_b fields
    localparam int         MUX_ENABLE_BIT    = 6;
    localparam int         TRIGGER_MSB       = 2;
    localparam logic [7:0] CONV_B_READ_MASK  = 8'h47;
    localparam logic [7:0] CONV_B_RESET      = 8'h00;

    // comparator_control_status fields
    localparam int         POWER_OFF_BIT     = 7;
    localparam int         BANDGAP_BIT       = 6;
    localparam int         RESULT_BIT        = 5;
    localparam int         IRQ_FLAG_BIT      = 4;
    localparam int         IRQ_ENABLE_BIT    = 3;
    localparam int         CAPTURE_ROUTE_BIT = 2;
    localparam int         MODE_MSB          = 1;
    localparam logic [7:0] CONTROL_RESET     = 8'h00;

    // digital_input_disable_one fields
    localparam int         NEG_BUF_OFF_BIT   = 1;
    localparam int         POS_BUF_OFF_BIT   = 0;
    localparam logic [1:0] BUF_OFF_RESET     = 2'h0;

    // Interrupt mode encodings
    localparam logic [1:0] MODE_TOGGLE       = 2'h0;
    localparam logic [1:0] MODE_RESERVED     = 2'h1;
    localparam logic [1:0] MODE_FALLING      = 2'h2;
    localparam logic [1:0] MODE_RISING       = 2'h3;

    // Synchroniser depth in flops
    localparam int         SYNC_STAGES       = 2;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       we;
        logic       re;
    } reg_req_t;

    typedef struct packed {
        logic       use_channel;
        logic [2:0] channel;
    } neg_sel_t;

endpackage

// >>> verif/test_comparator_control_logic.sv
// Self-checking bench for the comparator control logic.
// Assumes the design's own assertions sit inside the design file.
`timescale 1ns/1ns
module test_comparator_control_logic;
    import comparator_control_pkg::*;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rexp;
    } row_t;

    logic       i_mclk;
    logic       i_resetn;
    reg_req_t   req;
    logic [7:0] o_rdata;
    logic       raw;
    logic       o_bandgap_select;
    neg_sel_t   o_neg_sel;
    logic       o_comparator_power_off;
    logic       conv_en;
    logic [2:0] chan;
    logic [2:0] o_trigger_source_select;
    logic       gie;
    logic       vtaken;
    logic       o_irq;
    logic       cap_pin;
    logic       o_capture_source;
    logic       pos_pin;
    logic       neg_pin;
    logic       o_positive_pin_buffer_off;
    logic       o_negative_pin_buffer_off;
    logic [1:0] o_pin_level;
    int         num_errors;
    int         total_checks;
    int         cycles;
    logic       fl;
    row_t       rows [6];

    comparator_control_logic comparator_control_logic_i (
        .i_mclk(i_mclk), .i_resetn(i_resetn), .i_req(req), .o_rdata(o_rdata),
        .i_cmp_raw(raw), .o_bandgap_select(o_bandgap_select), .o_neg_sel(o_neg_sel),
        .o_comparator_power_off(o_comparator_power_off), .i_converter_enable(conv_en),
        .i_channel_select(chan), .o_trigger_source_select(o_trigger_source_select),
        .i_global_irq_enable(gie), .i_vector_taken(vtaken), .o_irq(o_irq),
        .i_capture_pin(cap_pin), .o_capture_source(o_capture_source),
        .i_positive_input_pin(pos_pin), .i_negative_input_pin(neg_pin),
        .o_positive_pin_buffer_off(o_positive_pin_buffer_off),
        .o_negative_pin_buffer_off(o_negative_pin_buffer_off), .o_pin_level(o_pin_level));

    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end

    task automatic test_done();
        if (num_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors = num_errors + 1;
            test_done();
        end
    end

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #10;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge i_mclk);
        req.we <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_mclk);
        req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(posedge i_mclk);
        req.re <= 1'b0;
        #10;
        chk_byte(o_rdata, exp);
    endtask

    task automatic set_raw(input logic v);
        @(posedge i_mclk);
        raw <= v;
        cyc(4);
    endtask

    initial begin
        i_resetn = 1'b0;
        req = '0;
        raw = 1'b0;
        conv_en = 1'b0;
        chan = 3'h0;
        gie = 1'b0;
        vtaken = 1'b0;
        cap_pin = 1'b0;
        pos_pin = 1'b0;
        neg_pin = 1'b0;
        num_errors = 0;
        total_checks = 0;
        cycles = 0;
        rows[0] = '{8'h7B, 8'hFF, 8'h47};
        rows[1] = '{8'h7B, 8'h00, 8'h00};
        rows[2] = '{8'h50, 8'h2C, 8'h0C};
        rows[3] = '{8'h7F, 8'hFF, 8'h03};
        rows[4] = '{8'h7F, 8'h00, 8'h00};
        rows[5] = '{8'h00, 8'hFF, 8'h00};
        repeat (12) @(posedge i_mclk);
        i_resetn <= 1'b1;
        rd(8'h7B, 8'h00);
        rd(8'h50, 8'h00);
        rd(8'h7F, 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, rows[i].rexp);
        end
        wr(8'h50, 8'h00);
        // Negative input selection depends on converter state too
        wr(8'h7B, 8'h47);
        chan <= 3'h5;
        cyc(1);
        chk_byte({4'h0, o_neg_sel}, 8'h0D);
        chk_byte({5'h00, o_trigger_source_select}, 8'h07);
        @(posedge i_mclk);
        conv_en <= 1'b1;
        cyc(1);
        chk_bit(o_neg_sel.use_channel, 1'b0);
        @(posedge i_mclk);
        conv_en <= 1'b0;
        wr(8'h7B, 8'h00);
        cyc(1);
        chk_bit(o_neg_sel.use_channel, 1'b0);
        wr(8'h50, 8'hC0);
        cyc(1);
        chk_bit(o_bandgap_select, 1'b1);
        chk_bit(o_comparator_power_off, 1'b1);
        wr(8'h50, 8'h00);
        cyc(1);
        chk_bit(o_bandgap_select, 1'b0);
        chk_bit(o_comparator_power_off, 1'b0);
        // Every mode, both edges; enable stays off while the mode changes
        for (int m = 0; m < 4; m++) begin
            wr(8'h50, 8'h10 | m[7:0]);
            set_raw(1'b1);
            fl = (m == 0 || m == 3);
            rd(8'h50, {3'h1, fl, 2'h0, m[1:0]});
            wr(8'h50, 8'h10 | m[7:0]);
            set_raw(1'b0);
            fl = (m == 0 || m == 2);
            rd(8'h50, {3'h0, fl, 2'h0, m[1:0]});
        end
        // Request needs flag, enable and global enable
        wr(8'h50, 8'h1B);
        gie <= 1'b1;
        set_raw(1'b1);
        chk_bit(o_irq, 1'b1);
        @(posedge i_mclk);
        gie <= 1'b0;
        cyc(1);
        chk_bit(o_irq, 1'b0);
        @(posedge i_mclk);
        gie <= 1'b1;
        wr(8'h50, 8'h0B);
        rd(8'h50, 8'h3B);
        @(posedge i_mclk);
        vtaken <= 1'b1;
        @(posedge i_mclk);
        vtaken <= 1'b0;
        #10;
        chk_bit(o_irq, 1'b0);
        rd(8'h50, 8'h2B);
        set_raw(1'b0);
        set_raw(1'b1);
        rd(8'h50, 8'h3B);
        wr(8'h50, 8'h1B);
        rd(8'h50, 8'h2B);
        @(posedge i_mclk);
        gie <= 1'b0;
        // Capture source follows the comparator only while routed
        wr(8'h50, 8'h04);
        cyc(3);
        chk_bit(o_capture_source, 1'b1);
        set_raw(1'b0);
        chk_bit(o_capture_source, 1'b0);
        wr(8'h50, 8'h00);
        cap_pin <= 1'b1;
        cyc(4);
        chk_bit(o_capture_source, 1'b1);
        // Pin levels read zero while their buffer is off
        @(posedge i_mclk);
        pos_pin <= 1'b1;
        neg_pin <= 1'b1;
        cyc(4);
        chk_byte({6'h00, o_pin_level}, 8'h03);
        wr(8'h7F, 8'h01);
        cyc(3);
        chk_byte({6'h00, o_pin_level}, 8'h02);
        chk_bit(o_positive_pin_buffer_off, 1'b1);
        chk_bit(o_negative_pin_buffer_off, 1'b0);
        // Mid-run reset with a live request: all returns to idle, pins resync
        wr(8'h50, 8'h08);
        gie <= 1'b1;
        cyc(1);
        chk_bit(o_irq, 1'b1);
        @(posedge i_mclk);
        i_resetn <= 1'b0;
        cyc(1);
        chk_bit(o_irq, 1'b0);
        chk_byte({6'h00, o_pin_level}, 8'h00);
        chk_bit(o_positive_pin_buffer_off, 1'b0);
        chk_bit(o_capture_source, 1'b0);
        chk_bit(o_comparator_power_off, 1'b0);
        @(posedge i_mclk);
        i_resetn <= 1'b1;
        rd(8'h50, 8'h00);
        chk_byte({6'h00, o_pin_level}, 8'h03);
        rd(8'h7B, 8'h00);
        test_done();
    end
endmodule
